// ==== design/fdma_map.svh ====
// register indices, field positions and reset values of the dma controller
`ifndef FDMA_MAP_SVH
`define FDMA_MAP_SVH
`define FDMA_IDX_GCSR 8'h00
`define FDMA_IDX_GIR 8'h01
`define FDMA_IDX_CH_BASE 8'h05
`define FDMA_CH_STRIDE 8'h05
`define FDMA_OFS_CR 8'h00
`define FDMA_OFS_SPR 8'h01
`define FDMA_OFS_NDTR 8'h02
`define FDMA_OFS_PARH 8'h03
`define FDMA_OFS_PARL 8'h04
`define FDMA_GCSR_RST 8'hFC
`define FDMA_CR_RST 7'h00
`define FDMA_PARH_RST 8'h52
`define FDMA_PARH3_RST 8'h40
`define FDMA_PARH_WMASK 8'h01
`define FDMA_PARH3_WMASK 8'h1F
`define FDMA_GEN_BIT 0
`define FDMA_WAIT_LSB 2
`define FDMA_CR_EN 0
`define FDMA_CR_DONE_IE 1
`define FDMA_CR_HALF_IE 2
`define FDMA_CR_DIR 3
`define FDMA_CR_RELOAD 4
`define FDMA_CR_SIGN 5
`define FDMA_CR_COPY 6
`define FDMA_SPR_DONE 1
`define FDMA_SPR_HALF 2
`define FDMA_SPR_WIDE 3
`define FDMA_SPR_RANK_LSB 4
`endif

// ==== design/fdma_pkg.sv ====
// shared types of the dma controller
package fdma_pkg;
   typedef enum logic [1:0] {FDMA_RANK_LOW, FDMA_RANK_MED, FDMA_RANK_HIGH, FDMA_RANK_VHIGH} fdma_rank_t;
   typedef enum logic [1:0] {FDMA_OKAY, FDMA_EXOKAY, FDMA_SLVERR, FDMA_DECERR} fdma_resp_t;
endpackage

// ==== design/fdma_reg_if.sv ====
// register access carrier between bus slave and register file
`timescale 1ns/100ps
interface fdma_reg_if;
   logic wr_stb;
   logic [7:0] wr_idx;
   logic [7:0] wr_data;
   logic wr_hit;
   logic [7:0] rd_idx;
   logic [7:0] rd_data;
   logic rd_hit;
   modport bus_end (output wr_stb, wr_idx, wr_data, rd_idx, input wr_hit, rd_data, rd_hit);
   modport reg_end (input wr_stb, wr_idx, wr_data, rd_idx, output wr_hit, rd_data, rd_hit);
endinterface

// ==== design/fdma_axil.sv ====
// axi4-lite slave front end of the dma register file
`timescale 1ns/100ps
module fdma_axil (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   fdma_reg_if.bus_end rb
);
   logic aw_full_reg;
   logic w_full_reg;
   logic w_lane_reg;
   logic [7:0] aw_idx_reg;
   logic [7:0] w_data_reg;
   logic do_wr;

   assign s_axi_awready = !aw_full_reg;
   assign s_axi_wready = !w_full_reg;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;
   // only byte lane 0 carries register bits
   assign rb.wr_stb = do_wr && w_lane_reg;
   assign rb.wr_idx = aw_idx_reg;
   assign rb.wr_data = w_data_reg;
   assign rb.rd_idx = s_axi_araddr[9:2];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         aw_full_reg <= 1'b0;
         aw_idx_reg <= 8'h00;
      end else if (s_axi_awvalid && !aw_full_reg) begin
         aw_full_reg <= 1'b1;
         aw_idx_reg <= s_axi_awaddr[9:2];
      end else if (do_wr) begin
         aw_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         w_full_reg <= 1'b0;
         w_data_reg <= 8'h00;
         w_lane_reg <= 1'b0;
      end else if (s_axi_wvalid && !w_full_reg) begin
         w_full_reg <= 1'b1;
         w_data_reg <= s_axi_wdata[7:0];
         w_lane_reg <= s_axi_wstrb[0];
      end else if (do_wr) begin
         w_full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else if (do_wr) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= rb.wr_hit ? fdma_pkg::FDMA_OKAY : fdma_pkg::FDMA_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rb.rd_data};
         s_axi_rresp <= rb.rd_hit ? fdma_pkg::FDMA_OKAY : fdma_pkg::FDMA_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ==== design/fdma_arb.sv ====
// channel rank arbiter and high priority wait counter
`timescale 1ns/100ps
module fdma_arb #(
   parameter int CHANNELS = 4
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [CHANNELS-1:0] want,
   input wire logic [2*CHANNELS-1:0] rank,
   input wire logic [5:0] wait_count,
   input wire logic served,
   output logic [1:0] pick,
   output logic any,
   output logic hipri
);
   logic [5:0] wait_cnt_reg;
   logic [1:0] best;
   logic vhigh;

   // highest rank wins, lower channel number breaks ties
   always_comb begin
      pick = 2'h0;
      best = 2'h0;
      any = 1'b0;
      vhigh = 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
         if (want[i] && (!any || rank[2*i +: 2] > best)) begin
            any = 1'b1;
            best = rank[2*i +: 2];
            pick = 2'(i);
         end
         if (want[i] && rank[2*i +: 2] == fdma_pkg::FDMA_RANK_VHIGH) begin
            vhigh = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wait_cnt_reg <= 6'h00;
      end else if (served || !any) begin
         wait_cnt_reg <= 6'h00;
      end else if (wait_cnt_reg < wait_count) begin
         wait_cnt_reg <= wait_cnt_reg + 6'h01;
      end
   end

   // zero wait count asks at once; a very high channel beats the cpu
   assign hipri = any && (vhigh || wait_cnt_reg >= wait_count);
endmodule

// ==== design/fdma_top.sv ====
// four channel dma controller: registers, channels and bus access
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "fdma_map.svh"
module fdma_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [9:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [9:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] periph_req,
   input wire logic halt_mode,
   input wire logic bus_grant,
   output logic bus_req,
   output logic bus_hipri,
   output logic xfer_stb,
   output logic [1:0] xfer_chan,
   output logic [15:0] xfer_src,
   output logic [15:0] xfer_dst,
   output logic xfer_word,
   output logic [3:0] chan_end,
   output logic [3:0] chan_irq,
   output logic wake
);
   localparam int CHANNELS = 4;
   localparam logic [7:0] GCSR_RST = `FDMA_GCSR_RST;

   fdma_reg_if rb ();

   logic global_enable_reg;
   logic [5:0] wait_count_reg;
   logic [3:0] req_s1_reg, req_s2_reg, req_d_reg, req_rise;
   logic global_active, grant_fire, arb_any, arb_hipri, wr_gcsr;
   logic [1:0] arb_pick;
   logic [7:0] gcsr_rd, gir_rd, ch_rd_data;
   logic ch_wr_hit, ch_rd_hit;

   wire [3:0] busy_v, want_v, flag_v, irq_v, end_v;
   wire [3:0] word_v, wr_hit_v, rd_hit_v;
   wire [7:0] rank_v;
   wire [15:0] src_v [CHANNELS];
   wire [15:0] dst_v [CHANNELS];
   wire [7:0] rd_v [CHANNELS];

   fdma_axil u_axil (
      .clk_sys(clk_sys),
      .rst(rst),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .rb(rb.bus_end)
   );

   fdma_arb #(
      .CHANNELS(CHANNELS)
   ) u_arb (
      .clk_sys(clk_sys),
      .rst(rst),
      .want(want_v),
      .rank(rank_v),
      .wait_count(wait_count_reg),
      .served(grant_fire),
      .pick(arb_pick),
      .any(arb_any),
      .hipri(arb_hipri)
   );

   // request pins come from other clock domains
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         req_s1_reg <= 4'h0;
         req_s2_reg <= 4'h0;
         req_d_reg <= 4'h0;
      end else begin
         req_s1_reg <= periph_req;
         req_s2_reg <= req_s1_reg;
         req_d_reg <= req_s2_reg;
      end
   end
   assign req_rise = req_s2_reg & ~req_d_reg;

   // halt freezes bus access; wait modes leave it alone
   assign bus_req = arb_any && !halt_mode;
   assign bus_hipri = arb_hipri && !halt_mode;
   assign grant_fire = bus_grant && arb_any && !halt_mode;

   assign global_active = |busy_v;
   assign wr_gcsr = rb.wr_stb && rb.wr_idx == `FDMA_IDX_GCSR;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         global_enable_reg <= GCSR_RST[`FDMA_GEN_BIT];
      end else if (wr_gcsr) begin
         global_enable_reg <= rb.wr_data[`FDMA_GEN_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wait_count_reg <= GCSR_RST[7:`FDMA_WAIT_LSB];
      end else if (wr_gcsr && !(global_enable_reg && global_active)) begin
         wait_count_reg <= rb.wr_data[7:`FDMA_WAIT_LSB];
      end
   end

   for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      localparam logic [7:0] BASE = 8'(`FDMA_IDX_CH_BASE + `FDMA_CH_STRIDE * c);
      localparam bit COPY_CH = (c == 3);
      localparam logic [7:0] PAH_MASK = COPY_CH ? `FDMA_PARH3_WMASK : `FDMA_PARH_WMASK;
      localparam logic [7:0] PAH_RST = COPY_CH ? `FDMA_PARH3_RST : `FDMA_PARH_RST;

      logic [6:0] cr_reg;
      logic [1:0] rank_reg;
      logic wide_reg;
      logic half_reg;
      logic done_reg;
      logic [7:0] cnt_reg;
      logic [7:0] prog_reg;
      logic [7:0] pah_reg;
      logic [7:0] pal_reg;
      logic [15:0] mem_reg;
      logic request_waiting_reg;
      logic sv_reg;
      logic act, copy, prot, take, accept;
      logic [7:0] nc;
      logic [15:0] step, pa;
      logic sel_cr, sel_spr, sel_cnt, sel_pah, sel_pal;

      assign act = global_enable_reg && cr_reg[`FDMA_CR_EN];
      assign copy = COPY_CH && cr_reg[`FDMA_CR_COPY];
      assign prot = act || busy_v[c];
      assign take = grant_fire && arb_pick == 2'(c);
      assign nc = cnt_reg - 8'h01;
      assign step = wide_reg ? 16'h0002 : 16'h0001;
      assign pa = {pah_reg, pal_reg};
      assign sel_cr = rb.wr_stb && rb.wr_idx == BASE + `FDMA_OFS_CR;
      assign sel_spr = rb.wr_stb && rb.wr_idx == BASE + `FDMA_OFS_SPR;
      assign sel_cnt = rb.wr_stb && rb.wr_idx == BASE + `FDMA_OFS_NDTR;
      assign sel_pah = rb.wr_stb && rb.wr_idx == BASE + `FDMA_OFS_PARH;
      assign sel_pal = rb.wr_stb && rb.wr_idx == BASE + `FDMA_OFS_PARL;
      // copy channel needs no peripheral request, it asks again once the previous transfer has been served
      assign accept = act && cnt_reg != 8'h00 && !request_waiting_reg
         && (copy ? !sv_reg : req_rise[c]);

      // enable stays writable so a locked channel can still be stopped
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            cr_reg <= `FDMA_CR_RST;
         end else if (sel_cr) begin
            cr_reg[`FDMA_CR_EN] <= rb.wr_data[`FDMA_CR_EN];
            if (!prot) begin
               cr_reg[`FDMA_CR_SIGN:`FDMA_CR_DONE_IE] <= rb.wr_data[5:1];
               cr_reg[`FDMA_CR_COPY] <= COPY_CH && rb.wr_data[`FDMA_CR_COPY];
            end
         end
      end

      always_ff @(posedge clk_sys) begin
         if (rst) begin
            rank_reg <= 2'h0;
            wide_reg <= 1'b0;
         end else if (sel_spr && !prot) begin
            rank_reg <= rb.wr_data[`FDMA_SPR_RANK_LSB +: 2];
            wide_reg <= rb.wr_data[`FDMA_SPR_WIDE];
         end
      end

      // clear by writing zero wins over a same-cycle set
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            half_reg <= 1'b0;
         end else if (sel_spr && !rb.wr_data[`FDMA_SPR_HALF]) begin
            half_reg <= 1'b0;
         end else if (take && prog_reg[7:1] != 7'h00
            && nc == prog_reg - {1'b0, prog_reg[7:1]}) begin
            half_reg <= 1'b1;
         end
      end

      always_ff @(posedge clk_sys) begin
         if (rst) begin
            done_reg <= 1'b0;
         end else if (sel_spr && !rb.wr_data[`FDMA_SPR_DONE]) begin
            done_reg <= 1'b0;
         end else if (take && nc == 8'h00) begin
            done_reg <= 1'b1;
         end
      end

      // hardware never clears the enable at zero count
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            cnt_reg <= 8'h00;
            prog_reg <= 8'h00;
         end else if (sel_cnt && !act) begin
            cnt_reg <= rb.wr_data;
            prog_reg <= rb.wr_data;
         end else if (take) begin
            if (nc == 8'h00 && cr_reg[`FDMA_CR_RELOAD] && !copy) begin
               cnt_reg <= prog_reg;
            end else begin
               cnt_reg <= nc;
            end
         end
      end

      // pointers move only on transfers, never on disable
      always_ff @(posedge clk_sys) begin
         if (rst) begin
            pah_reg <= PAH_RST;
            pal_reg <= 8'h00;
         end else if (sel_pah && !prot) begin
            pah_reg <= (PAH_RST & ~PAH_MASK) | (rb.wr_data & PAH_MASK);
         end else if (sel_pal && !prot) begin
            pal_reg <= rb.wr_data;
         end else if (take && copy) begin
            {pah_reg, pal_reg} <= cr_reg[`FDMA_CR_SIGN] ? pa + step : pa - step;
         end
      end

      always_ff @(posedge clk_sys) begin
         if (rst) begin
            mem_reg <= 16'h0000;
         end else if (take) begin
            if (copy || cr_reg[`FDMA_CR_SIGN]) begin
               mem_reg <= mem_reg + step;
            end else begin
               mem_reg <= mem_reg - step;
            end
         end
      end

      always_ff @(posedge clk_sys) begin
         if (rst) begin
            request_waiting_reg <= 1'b0;
            sv_reg <= 1'b0;
         end else begin
            request_waiting_reg <= act && (accept || (request_waiting_reg && !take));
            sv_reg <= take;
         end
      end

      assign want_v[c] = request_waiting_reg;
      assign busy_v[c] = request_waiting_reg || sv_reg;
      assign rank_v[2*c +: 2] = rank_reg;
      assign flag_v[c] = half_reg || done_reg;
      assign irq_v[c] = (half_reg && cr_reg[`FDMA_CR_HALF_IE])
         || (done_reg && cr_reg[`FDMA_CR_DONE_IE]);
      assign end_v[c] = take && nc == 8'h00;
      assign word_v[c] = wide_reg;
      // memory to memory ignores direction: memory is source
      assign src_v[c] = (copy || cr_reg[`FDMA_CR_DIR]) ? mem_reg : pa;
      assign dst_v[c] = (copy || cr_reg[`FDMA_CR_DIR]) ? pa : mem_reg;
      assign wr_hit_v[c] = rb.wr_idx >= BASE && rb.wr_idx <= BASE + `FDMA_OFS_PARL;
      assign rd_hit_v[c] = rb.rd_idx >= BASE && rb.rd_idx <= BASE + `FDMA_OFS_PARL;
      assign rd_v[c] = rb.rd_idx == BASE + `FDMA_OFS_CR ? {1'b0, cr_reg}
         : rb.rd_idx == BASE + `FDMA_OFS_SPR ? {busy_v[c], request_waiting_reg, rank_reg, wide_reg,
            half_reg, done_reg, 1'b0}
         : rb.rd_idx == BASE + `FDMA_OFS_NDTR ? cnt_reg
         : rb.rd_idx == BASE + `FDMA_OFS_PARH ? pah_reg
         : rb.rd_idx == BASE + `FDMA_OFS_PARL ? pal_reg : 8'h00;
   end

   // one transfer per grant, presented the cycle after
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         xfer_stb <= 1'b0;
         xfer_chan <= 2'h0;
         xfer_src <= 16'h0000;
         xfer_dst <= 16'h0000;
         xfer_word <= 1'b0;
      end else begin
         xfer_stb <= grant_fire;
         if (grant_fire) begin
            xfer_chan <= arb_pick;
            xfer_src <= src_v[arb_pick];
            xfer_dst <= dst_v[arb_pick];
            xfer_word <= word_v[arb_pick];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         chan_end <= 4'h0;
      end else begin
         chan_end <= end_v;
      end
   end

   assign chan_irq = irq_v;
   // flags can wake the core from wait, never from halt
   assign wake = |irq_v && !halt_mode;

   assign gcsr_rd = {wait_count_reg, global_active, global_enable_reg};
   assign gir_rd = {4'h0, flag_v};
   assign ch_wr_hit = |wr_hit_v;
   assign ch_rd_hit = |rd_hit_v;

   always_comb begin
      ch_rd_data = 8'h00;
      for (int i = 0; i < CHANNELS; i++) begin
         ch_rd_data = ch_rd_data | rd_v[i];
      end
   end

   assign rb.wr_hit = rb.wr_idx == `FDMA_IDX_GCSR || rb.wr_idx == `FDMA_IDX_GIR || ch_wr_hit;
   assign rb.rd_hit = rb.rd_idx == `FDMA_IDX_GCSR || rb.rd_idx == `FDMA_IDX_GIR || ch_rd_hit;
   assign rb.rd_data = rb.rd_idx == `FDMA_IDX_GCSR ? gcsr_rd
      : rb.rd_idx == `FDMA_IDX_GIR ? gir_rd : ch_rd_data;
endmodule

// ==== test/fdma_properties.sv ====
// port assertions of the dma controller top
`timescale 1ns/100ps
module fdma_properties (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic halt_mode,
   input wire logic bus_grant,
   input wire logic bus_req,
   input wire logic bus_hipri,
   input wire logic xfer_stb,
   input wire logic [1:0] xfer_chan,
   input wire logic [15:0] xfer_src,
   input wire logic [15:0] xfer_dst,
   input wire logic [3:0] chan_end,
   input wire logic [3:0] chan_irq,
   input wire logic wake
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_halt_quiet: assert property (halt_mode |-> !bus_req && !bus_hipri && !wake)
      else $error("bus activity while halted");
   a_halt_no_stb: assert property (halt_mode ##1 halt_mode |-> !xfer_stb)
      else $error("transfer while halted");
   a_grant_moves: assert property (bus_req && bus_grant |=> xfer_stb)
      else $error("grant without transfer");
   a_stb_cause: assert property (xfer_stb |-> $past(bus_req && bus_grant))
      else $error("transfer without grant");
   a_wake_irq: assert property (wake == ((|chan_irq) && !halt_mode))
      else $error("wake does not follow irq");
   a_end_chan: assert property (|chan_end |-> xfer_stb && chan_end == 4'h1 << xfer_chan)
      else $error("end pulse on wrong channel");
   a_hipri_req: assert property (bus_hipri |-> bus_req)
      else $error("urgent claim without request");
   // addresses only move with a served transfer
   a_ptr_hold: assert property (!(bus_req && bus_grant) |=> $stable(xfer_src) && $stable(xfer_dst))
      else $error("addresses moved without grant");
endmodule
bind fdma_top fdma_properties i_chk (.clk_sys, .rst, .halt_mode, .bus_grant, .bus_req,
   .bus_hipri, .xfer_stb, .xfer_chan, .xfer_src, .xfer_dst, .chan_end, .chan_irq, .wake);

// ==== test/fdma_far_model.sv ====
// peripheral request sources and cpu bus arbiter beside the dma controller
`timescale 1ns/100ps
module fdma_far_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] fire,
   input wire logic [3:0] slow,
   input wire logic bus_req,
   input wire logic bus_hipri,
   output logic [3:0] periph_req,
   output logic bus_grant
);
   logic [3:0] wait_cnt;
   logic [1:0] hold_cnt;
   // level held a few cycles so the synchroniser sees one clean edge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         periph_req <= 4'h0;
         hold_cnt <= 2'h0;
      end else if (|fire) begin
         periph_req <= fire;
         hold_cnt <= 2'h3;
      end else if (hold_cnt != 2'h0) begin
         hold_cnt <= hold_cnt - 2'h1;
      end else begin
         periph_req <= 4'h0;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst || !bus_req || bus_grant) begin
         wait_cnt <= 4'h0;
      end else if (wait_cnt != 4'hF) begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
   // cpu yields late unless the claim is urgent
   assign bus_grant = bus_req && (bus_hipri || wait_cnt >= slow);
endmodule

// ==== test/tb_top.sv ====
// self-checking bench of the dma controller
`timescale 1ns/100ps
module tb_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [9:0] s_axi_awaddr = 10'h000;
   logic [9:0] s_axi_araddr = 10'h000;
   logic [31:0] s_axi_wdata = 32'h00000000;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic halt_mode = 1'b0;
   logic [3:0] fire = 4'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic bus_req, bus_hipri, bus_grant, xfer_stb, xfer_word, wake;
   logic [1:0] s_axi_bresp, s_axi_rresp, xfer_chan;
   logic [31:0] s_axi_rdata;
   logic [15:0] xfer_src, xfer_dst;
   logic [3:0] periph_req, chan_end, chan_irq;
   int errors = 0;
   int comparisons = 0;
   int stbs = 0;
   fdma_top i_dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .periph_req, .halt_mode,
      .bus_grant, .bus_req, .bus_hipri, .xfer_stb, .xfer_chan, .xfer_src, .xfer_dst,
      .xfer_word, .chan_end, .chan_irq, .wake);
   fdma_far_model i_far (.clk_sys, .rst, .fire, .slow(4'h3), .bus_req, .bus_hipri,
      .periph_req, .bus_grant);
   initial forever #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (xfer_stb === 1'b1) stbs <= stbs + 1;
   task automatic stop_test;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %0t mismatch got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] d);
      @(posedge clk_sys);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk(16'({s_axi_bvalid, s_axi_bresp}), 16'h0004);
   endtask
   task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er = 2'h0);
      @(posedge clk_sys);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk(16'({s_axi_rvalid, s_axi_rresp, s_axi_rdata[7:0]}), 16'({1'b1, er, e}));
   endtask
   // fixed wait: an absent transfer can only be judged after a span
   task automatic req(input logic [3:0] c, input int n);
      int s0;
      s0 = stbs;
      @(posedge clk_sys);
      fire <= c;
      @(posedge clk_sys);
      fire <= 4'h0;
      repeat (20) @(posedge clk_sys);
      chk(16'(stbs - s0), 16'(n));
   endtask
   task automatic t_reset;
      rd(8'h00, 8'hFC);
      rd(8'h01, 8'h00);
      rd(8'h08, 8'h52);
      rd(8'h17, 8'h40);
      rd(8'h03, 8'h00, 2'h2);
      $display("t_reset done");
   endtask
   task automatic t_regs;
      wr(8'h08, 8'hFF);
      rd(8'h08, 8'h53);
      wr(8'h05, 8'h40);
      rd(8'h05, 8'h00);
      wr(8'h14, 8'h40);
      rd(8'h14, 8'h40);
      wr(8'h14, 8'h00);
      wr(8'h06, 8'hFE);
      rd(8'h06, 8'h38);
      wr(8'h06, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_xfer;
      wr(8'h09, 8'h34);
      wr(8'h07, 8'h02);
      wr(8'h05, 8'h07);
      wr(8'h00, 8'h21);
      req(4'h1, 1);
      chk(xfer_src, 16'h5334);
      rd(8'h07, 8'h01);
      rd(8'h06, 8'h04);
      req(4'h1, 1);
      rd(8'h07, 8'h00);
      rd(8'h06, 8'h06);
      rd(8'h01, 8'h01);
      chk(16'(chan_irq), 16'h0001);
      req(4'h1, 0);
      wr(8'h05, 8'h0F);
      rd(8'h05, 8'h07);
      wr(8'h07, 8'h05);
      rd(8'h07, 8'h00);
      wr(8'h06, 8'h00);
      rd(8'h01, 8'h00);
      $display("t_xfer done");
   endtask
   task automatic t_gate;
      wr(8'h00, 8'h20);
      rd(8'h09, 8'h34);
      wr(8'h07, 8'h01);
      req(4'h1, 0);
      wr(8'h00, 8'h21);
      halt_mode <= 1'b1;
      req(4'h1, 0);
      wr(8'h00, 8'hFD);
      rd(8'h00, 8'h23);
      halt_mode <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rd(8'h06, 8'h02);
      $display("t_gate done");
   endtask
   task automatic t_reload;
      wr(8'h0B, 8'h38);
      wr(8'h0C, 8'h02);
      wr(8'h0A, 8'h19);
      req(4'h2, 1);
      req(4'h2, 1);
      chk(xfer_dst, 16'h5200);
      chk(16'(xfer_word), 16'h0001);
      rd(8'h0C, 8'h02);
      rd(8'h0B, 8'h3E);
      wr(8'h16, 8'h02);
      wr(8'h14, 8'h51);
      req(4'h0, 2);
      rd(8'h16, 8'h00);
      chk(xfer_src, 16'h0001);
      chk(xfer_dst, 16'h3FFF);
      $display("t_reload done");
   endtask
   initial begin
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      t_reset;
      t_regs;
      t_xfer;
      t_gate;
      t_reload;
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      stop_test;
   end
endmodule
